// ### spi_port_pkg.sv
// Shared constants for the serial register port and its controller
package spi_port_pkg;
   // Command layout
   localparam int CMD_RW_BIT = 7;
   localparam logic [6:0] PAGE_OFF_1B = 7'h7c;
   localparam logic [14:0] PAGE_OFF_2B = 15'h7ffc;
   localparam logic [7:0] PAGE_CMD_1B = 8'h7c;
   localparam logic [15:0] PAGE_CMD_2B = 16'h7ffd;
   localparam logic [31:0] PAGE_RST = 32'h0000_0000;
   localparam int REG_AW = 16;
   // Frame and header lengths in bits
   localparam logic [5:0] BITS_1B = 6'd16;
   localparam logic [5:0] BITS_2B = 6'd24;
   localparam logic [5:0] BITS_PAGE = 6'd40;
   localparam logic [5:0] HDR_1B = 6'd8;
   localparam logic [5:0] HDR_2B = 6'd16;
   // Timing
   localparam int CLK_MHZ = 40;
   localparam int SCLK_MAX_MHZ = 50;
   localparam int RELEASE_NS = 10;
   localparam int HALF_MIN = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
   // Read path sync latency needs at least four cycles per half period
   localparam int HALF_DEF = (HALF_MIN > 4) ? HALF_MIN : 4;
   // Controller register map
   localparam logic [3:0] CTRL_OFF = 4'h0;
   localparam logic [3:0] CMD_OFF = 4'h4;
   localparam logic [3:0] WDAT_OFF = 4'h8;
   localparam logic [3:0] STAT_OFF = 4'hc;
   localparam int CTRL_START = 0;
   localparam int CTRL_TWO_BYTE = 1;
   localparam int CTRL_THREE_WIRE = 2;
   localparam int CTRL_RD_DELAY = 3;
   localparam int CMD_RW = 16;
   localparam int CMD_PAGE = 17;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### spi_link_if.sv
// Serial link between controller and register port
`timescale 1ns/1ps
interface spi_link_if;
   logic sclk;
   logic cs_n;
   logic serial_data_in;
   logic host_sdio_o;
   logic host_sdio_oe_n;
   logic dev_sdio_o;
   logic dev_sdio_oe_n;
   logic sdio;
   // Pull-up when nobody drives
   assign sdio = !dev_sdio_oe_n ? dev_sdio_o : (!host_sdio_oe_n ? host_sdio_o : 1'b1);
   modport host (output sclk, output cs_n, output serial_data_in, output host_sdio_o,
      output host_sdio_oe_n, input sdio);
   modport device (input sclk, input cs_n, input serial_data_in, input sdio,
      output dev_sdio_o, output dev_sdio_oe_n);
endinterface

// ### bit_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t s;
   sync_t next_s;
   always_comb begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign q = s.s2;
endmodule

// ### spi_port_device.sv
// Register port end of the serial link, clocked by the link clock; the write report is retimed to clk
// Functional notes
// (R1) Command MSB low: store following data bytes
// (R2) Command MSB high: shift register contents out
// (R3) One-byte mode: page loaded via offset 7C
// (R4) Two-byte mode: page loaded via 7FFD
// (R5) Link clock at most 50 MHz
// (R6) Optional half-period delay on read data
// (R7) Data line released once chip select rises
// (R8) One-byte address: 9 page bits, 7 command
// (R9) Two-byte address: 1 page bit, 15 command
// (R10) Pointer advances after every data byte
// (R11) Four-wire default, three-wire on one line
// (R12) Chip select high aborts, decoder idles
`timescale 1ns/1ps
module spi_port_device #(
   parameter int MEM_AW = 6
) (
   input wire logic clk,
   input wire logic rst,
   spi_link_if.device link,
   input wire logic two_byte,
   input wire logic three_wire,
   input wire logic rd_delay,
   output logic wr_stb,
   output logic [spi_port_pkg::REG_AW-1:0] wr_addr,
   output logic [7:0] wr_data
);
   import spi_port_pkg::*;

   typedef enum logic [1:0] {S_CMD = 2'b00, S_OFF = 2'b01, S_DATA = 2'b11} phase_t;
   typedef struct packed {
      phase_t st;
      logic [2:0] cnt;
      logic [6:0] sh;
      logic rw;
      logic [14:0] ptr;
      logic [7:0] tx;
      logic drv;
   } frame_t;
   typedef struct packed {
      logic [3:0][7:0] page;
      logic tog;
      logic [REG_AW-1:0] wa;
      logic [7:0] wd;
   } keep_t;
   typedef struct packed {
      logic td;
      logic stb;
      logic [REG_AW-1:0] addr;
      logic [7:0] data;
   } user_t;

   frame_t f;
   frame_t next_f;
   keep_t k;
   keep_t next_k;
   user_t u;
   user_t next_u;
   logic [7:0] mem [2**MEM_AW];
   logic [2:0] cfg;
   logic tb;
   logic tw;
   logic dly;
   logic din;
   logic [7:0] b;
   logic enter_rd;
   logic mem_we;
   logic [MEM_AW-1:0] mem_wa;
   logic [7:0] mem_wd;
   logic [REG_AW-1:0] wa16;
   logic [14:0] ptr_inc;
   logic tog_s;
   logic out_n;
   logic oe_neg_n;
   logic out_p;
   logic oe_pos_n;

   // Mode levels are static in use; they settle within two link clocks
   bit_sync #(.W(3)) cfg_sync (
      .clk(link.sclk),
      .rst(rst),
      .d({two_byte, three_wire, rd_delay}),
      .q(cfg)
   );
   bit_sync #(.W(1)) tog_sync (
      .clk(clk),
      .rst(rst),
      .d(k.tog),
      .q(tog_s)
   );

   assign tb = cfg[2];
   assign tw = cfg[1];
   assign dly = cfg[0];
   assign din = tw ? link.sdio : link.serial_data_in; // [R11]

   function automatic logic [REG_AW-1:0] full_addr(input logic [14:0] p);
      if (tb) begin
         full_addr = {k.page[1][7], p}; // [R9]
      end else begin
         full_addr = {k.page[1], k.page[0][7], p[6:0]}; // [R8]
      end
   endfunction

   function automatic logic page_hit(input logic [14:0] p);
      if (tb) begin
         page_hit = (p[14:2] == PAGE_OFF_2B[14:2]); // [R4]
      end else begin
         page_hit = (p[6:2] == PAGE_OFF_1B[6:2]); // [R3]
      end
   endfunction

   function automatic logic [7:0] rd_byte(input logic [14:0] p);
      logic [REG_AW-1:0] a;
      a = full_addr(p);
      if (page_hit(p)) begin
         rd_byte = k.page[p[1:0]];
      end else begin
         rd_byte = mem[a[MEM_AW-1:0]];
      end
   endfunction

   // One-byte bursts wrap inside the 128-byte page
   function automatic logic [14:0] nxt(input logic [14:0] p);
      if (tb) begin
         nxt = p + 15'd1;
      end else begin
         nxt = {8'h00, 7'(p[6:0] + 7'd1)};
      end
   endfunction

   always_comb begin
      next_f = f;
      next_k = k;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      enter_rd = 1'b0;
      wa16 = full_addr(f.ptr);
      ptr_inc = nxt(f.ptr);
      b = {f.sh, din};
      next_f.cnt = f.cnt + 3'd1;
      next_f.sh = b[6:0];
      next_f.tx = {f.tx[6:0], 1'b0};
      if (f.cnt == 3'd7) begin
         case (f.st)
            S_CMD: begin
               next_f.rw = b[CMD_RW_BIT]; // [R1] [R2]
               if (tb) begin
                  next_f.ptr = {b[6:0], 8'h00};
                  next_f.st = S_OFF;
               end else begin
                  next_f.ptr = {8'h00, b[6:0]};
                  next_f.st = S_DATA;
                  enter_rd = b[CMD_RW_BIT];
               end
            end
            S_OFF: begin
               next_f.ptr = {f.ptr[14:8], b};
               next_f.st = S_DATA;
               enter_rd = f.rw;
            end
            S_DATA: begin
               next_f.ptr = ptr_inc; // [R10]
               if (f.rw) begin
                  next_f.tx = rd_byte(ptr_inc); // [R2] [R10]
               end else begin
                  if (page_hit(f.ptr)) begin
                     next_k.page[f.ptr[1:0]] = b; // [R3] [R4]
                  end else begin
                     mem_we = 1'b1; // [R1]
                     mem_wa = wa16[MEM_AW-1:0];
                     mem_wd = b;
                  end
                  next_k.tog = ~k.tog;
                  next_k.wa = wa16;
                  next_k.wd = b;
               end
            end
            default: begin
               next_f.st = S_CMD;
            end
         endcase
      end
      if (enter_rd) begin
         next_f.tx = rd_byte(next_f.ptr); // [R2]
         next_f.drv = 1'b1;
      end
   end

   // Chip select high resets the frame state asynchronously
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         f <= '0; // [R12]
      end else begin
         f <= next_f;
      end
   end

   // Page and write report survive between frames
   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         k <= '{page: PAGE_RST, tog: 1'b0, wa: '0, wd: '0};
      end else begin
         k <= next_k;
      end
   end

   always_ff @(posedge link.sclk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // Read bit launched on the falling edge
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         out_n <= 1'b1; // [R7]
         oe_neg_n <= 1'b1;
      end else begin
         out_n <= f.tx[7];
         oe_neg_n <= ~f.drv;
      end
   end

   // Same bit half a period later, on the rising edge
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         out_p <= 1'b1; // [R7]
         oe_pos_n <= 1'b1;
      end else begin
         out_p <= out_n; // [R6]
         oe_pos_n <= oe_neg_n;
      end
   end

   assign link.dev_sdio_o = dly ? out_p : out_n; // [R6]
   assign link.dev_sdio_oe_n = dly ? oe_pos_n : oe_neg_n; // [R7]

   // Write report moves to clk by toggle; address and data are stable by then
   always_comb begin
      next_u = u;
      next_u.stb = 1'b0;
      next_u.td = tog_s;
      if (tog_s != u.td) begin
         next_u.stb = 1'b1;
         next_u.addr = k.wa;
         next_u.data = k.wd;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         u <= '0;
      end else begin
         u <= next_u;
      end
   end

   assign wr_stb = u.stb;
   assign wr_addr = u.addr;
   assign wr_data = u.data;
endmodule

// ### spi_port_host.sv
// Link controller end: AXI4-Lite command registers, makes the link clock
`timescale 1ns/1ps
module spi_port_host #(
   parameter int HALF = spi_port_pkg::HALF_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   spi_link_if.host link
);
   import spi_port_pkg::*;

   typedef enum logic [2:0] {H_IDLE = 3'b000, H_SETUP = 3'b001, H_HIGH = 3'b011,
      H_LOW = 3'b010, H_TAIL = 3'b111} hstate_t;
   typedef struct packed {
      hstate_t st;
      logic [7:0] div;
      logic [5:0] cnt;
      logic [5:0] nbits;
      logic [5:0] rel_at;
      logic rd;
      logic [39:0] tx;
      logic [7:0] rx;
      logic sclk;
      logic cs_n;
      logic mosi;
      logic oe_n;
      logic two_byte;
      logic three_wire;
      logic rd_delay;
      logic [17:0] cmd;
      logic [7:0] wdat;
      logic done;
      logic aw_got;
      logic [3:0] awa;
      logic w_got;
      logic [31:0] wd;
      logic [3:0] ws;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } host_t;

   localparam logic [7:0] HALF_M1 = 8'(HALF - 1); // [R5]

   host_t s;
   host_t next_s;
   logic miso;
   logic [31:0] m;
   logic [15:0] a;
   logic edge_end;

   bit_sync #(.W(1)) miso_sync (
      .clk(clk),
      .rst(rst),
      .d(link.sdio),
      .q(miso)
   );

   always_comb begin
      next_s = s;
      m = '0;
      a = s.cmd[15:0];
      edge_end = (s.div == HALF_M1);
      // Register bus
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wd = s_axi_wdata;
         next_s.ws = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = s.ws[i] ? 8'hff : 8'h00;
         end
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         case (s.awa)
            CTRL_OFF: begin
               if (s.st == H_IDLE && s.ws[0]) begin
                  next_s.two_byte = s.wd[CTRL_TWO_BYTE];
                  next_s.three_wire = s.wd[CTRL_THREE_WIRE];
                  next_s.rd_delay = s.wd[CTRL_RD_DELAY];
                  if (s.wd[CTRL_START]) begin
                     next_s.st = H_SETUP;
                     next_s.div = '0;
                     next_s.cnt = '0;
                     next_s.cs_n = 1'b0;
                     next_s.oe_n = ~s.wd[CTRL_THREE_WIRE]; // [R11]
                     next_s.rd = s.cmd[CMD_RW] && !s.cmd[CMD_PAGE];
                     next_s.rel_at = s.wd[CTRL_TWO_BYTE] ? HDR_2B : HDR_1B;
                     if (s.cmd[CMD_PAGE]) begin
                        next_s.nbits = BITS_PAGE;
                        if (s.wd[CTRL_TWO_BYTE]) begin
                           next_s.tx = {PAGE_CMD_2B, a[15:8], 16'h0000}; // [R4]
                        end else begin
                           next_s.tx = {PAGE_CMD_1B, a[7:0], a[15:8], 16'h0000}; // [R3]
                        end
                     end else if (s.wd[CTRL_TWO_BYTE]) begin
                        next_s.nbits = BITS_2B;
                        next_s.tx = {s.cmd[CMD_RW], a[14:0], s.wdat, 16'h0000}; // [R1] [R2]
                     end else begin
                        next_s.nbits = BITS_1B;
                        next_s.tx = {s.cmd[CMD_RW], a[6:0], s.wdat, 24'h000000}; // [R1] [R2]
                     end
                     next_s.mosi = next_s.tx[39];
                  end
               end
            end
            CMD_OFF: next_s.cmd = (s.cmd & ~m[17:0]) | (s.wd[17:0] & m[17:0]);
            WDAT_OFF: next_s.wdat = (s.wdat & ~m[7:0]) | (s.wd[7:0] & m[7:0]);
            STAT_OFF: begin
               if (s.ws[0] && s.wd[ST_DONE]) begin
                  next_s.done = 1'b0;
               end
            end
            default: next_s.bresp = RESP_SLVERR;
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         case (s_axi_araddr)
            CTRL_OFF: next_s.rdata = {28'h0, s.rd_delay, s.three_wire, s.two_byte, 1'b0};
            CMD_OFF: next_s.rdata = {14'h0, s.cmd};
            WDAT_OFF: next_s.rdata = {24'h0, s.wdat};
            STAT_OFF: next_s.rdata = {16'h0, s.rx, 6'h0, s.done, s.st != H_IDLE};
            default: begin
               next_s.rdata = '0;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      // Link sequencer; plain delivery is sampled before each rise
      if (s.st != H_IDLE) begin
         next_s.div = s.div + 8'd1;
         if (edge_end) begin
            next_s.div = '0;
            case (s.st)
               H_SETUP, H_LOW: begin
                  if (!s.rd_delay) begin
                     next_s.rx = {s.rx[6:0], miso};
                  end
                  next_s.sclk = 1'b1;
                  next_s.st = H_HIGH;
               end
               H_HIGH: begin
                  if (s.rd_delay) begin
                     next_s.rx = {s.rx[6:0], miso}; // [R6]
                  end
                  next_s.sclk = 1'b0;
                  next_s.cnt = s.cnt + 6'd1;
                  next_s.tx = {s.tx[38:0], 1'b0};
                  next_s.mosi = s.tx[38];
                  if (s.rd && (s.cnt + 6'd1 == s.rel_at)) begin
                     next_s.oe_n = 1'b1;
                  end
                  next_s.st = (s.cnt + 6'd1 == s.nbits) ? H_TAIL : H_LOW;
               end
               H_TAIL: begin
                  next_s.cs_n = 1'b1;
                  next_s.oe_n = 1'b1;
                  next_s.st = H_IDLE;
                  next_s.done = 1'b1;
               end
               default: next_s.st = H_IDLE;
            endcase
         end
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{st: H_IDLE, cs_n: 1'b1, oe_n: 1'b1, mosi: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign link.sclk = s.sclk;
   assign link.cs_n = s.cs_n;
   assign link.serial_data_in = s.mosi;
   assign link.host_sdio_o = s.mosi;
   assign link.host_sdio_oe_n = s.oe_n;
endmodule

// ### spi_link_properties.sv
// Timing and framing checks on the serial link between both ends
`timescale 1ns/1ps
module spi_link_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_data_in,
   input wire logic host_sdio_oe_n,
   input wire logic dev_sdio_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic sclk_q;
   logic [6:0] rises;
   // Rising link edges seen in the current frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         rises <= 7'h00;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            rises <= 7'h00;
         end else if (sclk && !sclk_q) begin
            rises <= rises + 7'h01;
         end
      end
   end
   sequence s_half_high;
      sclk [*4];
   endsequence
   sequence s_half_low;
      !sclk [*4];
   endsequence
   property p_release;
      cs_n |-> dev_sdio_oe_n;
   endproperty
   property p_idle_low;
      cs_n |-> !sclk;
   endproperty
   property p_frame_len;
      $rose(cs_n) |-> (rises == 7'd16 || rises == 7'd24 || rises == 7'd40);
   endproperty
   property p_high_width;
      $rose(sclk) |-> s_half_high;
   endproperty
   property p_low_width;
      $fell(sclk) && !cs_n |-> s_half_low;
   endproperty
   property p_cs_setup;
      $fell(cs_n) |-> s_half_low;
   endproperty
   // Data may only move while the link clock is low
   property p_data_hold;
      sclk && sclk_q && !cs_n |-> $stable(serial_data_in);
   endproperty
   property p_no_fight;
      !(!dev_sdio_oe_n && !host_sdio_oe_n);
   endproperty
   a_release: assert property (p_release) else $error("data line held after deselect");
   a_idle_low: assert property (p_idle_low) else $error("link clock not idle low");
   a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
   a_high_width: assert property (p_high_width) else $error("clock high too short");
   a_low_width: assert property (p_low_width) else $error("clock low too short");
   a_cs_setup: assert property (p_cs_setup) else $error("select setup too short");
   a_data_hold: assert property (p_data_hold) else $error("data moved while high");
   a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
endmodule

// ### testbench.sv
// Self-checking bench: controller and register port joined over the link
`timescale 1ns/1ps
module testbench;
   import spi_port_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b0;
   logic [2:0] mode_now = 3'b000;
   logic abort_rst = 1'b0;
   logic rst_h;
   logic [3:0] awaddr = 4'h0;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [3:0] araddr = 4'h0;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic two_byte = 1'b0;
   logic three_wire = 1'b0;
   logic rd_delay = 1'b0;
   logic wr_stb;
   logic [15:0] wr_addr;
   logic [7:0] wr_data;
   logic [31:0] stat_last;
   logic [31:0] d;
   logic [1:0] r;
   logic [23:0] got[$];
   logic [7:0] pg1 [4] = '{8'h80, 8'hcb, 8'h00, 8'h00};
   int mismatches = 0;
   int tests_run = 0;
   int base;
   always #12.5 clk = ~clk;
   // Extra reset lets the controller drop a frame half way
   assign rst_h = rst | abort_rst;
   spi_link_if link_a ();
   spi_port_host #(.HALF(4)) spi_port_host_i (.clk(clk), .rst(rst_h),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .link(link_a));
   spi_port_device spi_port_device_i (.clk(clk), .rst(rst), .link(link_a),
      .two_byte(two_byte), .three_wire(three_wire), .rd_delay(rd_delay),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
   spi_link_properties spi_link_properties_i (.clk(clk), .rst(rst_h), .sclk(link_a.sclk),
      .cs_n(link_a.cs_n), .serial_data_in(link_a.serial_data_in),
      .host_sdio_oe_n(link_a.host_sdio_oe_n), .dev_sdio_oe_n(link_a.dev_sdio_oe_n));
   always @(posedge clk) begin
      if (wr_stb === 1'b1) begin
         got.push_back({wr_addr, wr_data});
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("mismatches %0d comparisons %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task timeout;
      mismatches++;
      $display("[FAIL] %0t: wait ran out", $time);
      end_sim();
   endtask
   task axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
      int n;
      logic aw_p;
      logic w_p;
      logic fin;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      fin = 1'b0;
      n = 0;
      while (!fin && n < 300) begin
         @(posedge clk);
         n++;
         if (aw_p && awready) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            resp = bresp;
            bready <= 1'b0;
            fin = 1'b1;
         end
      end
      if (!fin) timeout();
   endtask
   task axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      logic fin;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      fin = 1'b0;
      n = 0;
      while (!fin && n < 300) begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            v = rdata;
            resp = rresp;
            rready <= 1'b0;
            fin = 1'b1;
         end
      end
      if (!fin) timeout();
   endtask
   // Mode is {rd_delay, three_wire, two_byte}; device levels follow the controller's
   // Device mode levels cross on link clock edges only: a throwaway read flushes a change
   task frame(input logic [2:0] m, input logic [17:0] cmd, input logic [7:0] wd, input bit wt);
      int n;
      two_byte <= m[0];
      three_wire <= m[1];
      rd_delay <= m[2];
      for (int k = (m == mode_now) ? 1 : 0; k < 2; k++) begin
         axi_write(CMD_OFF, (k == 0) ? 32'h0001_0000 : {14'h0, cmd}, r);
         axi_write(WDAT_OFF, {24'h0, wd}, r);
         axi_write(CTRL_OFF, {28'h0, m, 1'b1}, r);
         if (wt || k == 0) begin
            stat_last = 32'h0;
            n = 0;
            while (stat_last[ST_DONE] !== 1'b1 && n < 300) begin
               axi_read(STAT_OFF, stat_last, r);
               n++;
            end
            if (stat_last[ST_DONE] !== 1'b1) timeout();
            axi_write(STAT_OFF, 32'h2, r);
         end
      end
      mode_now = m;
   endtask
   initial begin
      // Raised by update so every asynchronous reset sees a clean rising edge
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      axi_read(STAT_OFF, d, r);
      chk(d, 32'h0);
      axi_read(4'h2, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_write(4'h2, 32'h0, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_write(WDAT_OFF, 32'h5a, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      axi_read(WDAT_OFF, d, r);
      chk(d, 32'h5a);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      base = got.size();
      frame(3'b000, {2'b10, 16'hcb80}, 8'h00, 1);
      chk(32'(got.size() - base), 32'd4);
      for (int i = 0; i < 4; i++) begin
         chk({24'h0, got[base + i][7:0]}, {24'h0, pg1[i]});
      end
      // Every pairing of line count and read delay in short offsets
      for (int i = 0; i < 4; i++) begin
         frame({i[1:0], 1'b0}, {2'b00, 16'hcbe4 + 16'(i)}, 8'h50 + 8'(i), 1);
         chk({8'h0, got[$]}, {8'h0, 16'hcbe4 + 16'(i), 8'h50 + 8'(i)});
         frame({i[1:0], 1'b0}, {2'b01, 16'hcbe4 + 16'(i)}, 8'h00, 1);
         chk({24'h0, stat_last[15:8]}, {24'h0, 8'h50 + 8'(i)});
      end
      base = got.size();
      frame(3'b001, {2'b10, 16'h8000}, 8'h00, 1);
      chk(32'(got.size() - base), 32'd3);
      chk({24'h0, got[base][7:0]}, 32'h80);
      frame(3'b001, {2'b00, 16'hcbe4}, 8'ha5, 1);
      chk({8'h0, got[$]}, {8'h0, 16'hcbe4, 8'ha5});
      frame(3'b111, {2'b01, 16'hcbe4}, 8'h00, 1);
      chk({24'h0, stat_last[15:8]}, 32'ha5);
      // Controller dropped in mid header: nothing may be written
      base = got.size();
      frame(3'b001, {2'b00, 16'hcbe8}, 8'h3c, 0);
      repeat (40) @(posedge clk);
      abort_rst <= 1'b1;
      repeat (2) @(posedge clk);
      abort_rst <= 1'b0;
      repeat (300) @(posedge clk);
      chk(32'(got.size() - base), 32'd0);
      frame(3'b001, {2'b00, 16'hcbe8}, 8'h3c, 1);
      chk({8'h0, got[$]}, {8'h0, 16'hcbe8, 8'h3c});
      end_sim();
   end
endmodule
